// ---- lcdid_decoder.sv ----
/*
  Instruction decoder and executor for a character LCD controller: each accepted host
  transfer posted over APB is classified, run and kept busy for its time.
  Assumes a synchronous active-high reset and a 250 MHz clock.
*/
// Notes on behaviour
// - Latch instructions and data into holding registers
// - Three select bits choose the transfer type
// - Instruction chosen by highest one in D6..D0, none when it is D5; with D7 set, D6 picks CG or DD
// - Execution times 217us, 290us, 1.38ms or zero
// - All-zero low byte enters maker test mode
// - Clear display when D0 alone, 1.38ms
// - Clear fills spaces, zeroes counter, sets increment
// - Clear returns cursor to leftmost position
// - Clear keeps shift flag, user and icon RAM
// - Return home zeroes the address counter
// - Return home cancels display shift
// - Return home leaves display RAM untouched
// - Display state changes only on accepted transfer or reset
// - Counter steps by entry direction per access
`timescale 1ns/1ps
`default_nettype none
module lcdid_decoder
  import lcdid_pkg::*;
#(
  parameter int STD_CYC   = EXEC_STD_CYC,
  parameter int SHIFT_CYC = EXEC_SHIFT_CYC,
  parameter int CLEAR_CYC = EXEC_CLEAR_CYC
)(
  // Clock and reset.
  input  wire logic        clock,
  input  wire logic        rst,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Sensed inputs.
  input  wire logic [7:0]  input_port_pins,
  input  wire logic [11:0] key_data,
  // Display state.
  output logic             busy_flag,
  output logic [5:0]       address_counter,
  output logic [3:0]       display_shift,
  output logic [2:0]       display_ctrl,
  output logic [3:0]       sample_rate,
  output logic [5:0]       port_out,
  output logic [1:0]       port_pattern,
  output logic             test_mode
);
  lcdid_state_t     state_reg, state_next;
  logic [CNT_W-1:0] count_reg, count_next;
  logic [15:0]      instr_reg, instr_next, data_reg, data_next;
  logic [15:0]      rdata_reg, rdata_next;
  logic [31:0]      prdata_reg, prdata_next;
  logic [5:0]       ac_reg, ac_next;
  logic             cg_reg, cg_next;
  logic             inc_reg, inc_next;
  logic             shift_reg, shift_next;
  logic [3:0]       ofs_reg, ofs_next;
  logic [2:0]       disp_reg, disp_next;
  logic [3:0]       rate_reg, rate_next;
  logic [5:0]       port_reg, port_next;
  logic [1:0]       pat_reg, pat_next;
  logic             test_reg, test_next;
  logic             drop_reg, drop_next;
  logic [7:0]       dd_mem [DD_DEPTH], dd_next [DD_DEPTH];
  logic [4:0]       cg_mem [CG_DEPTH], cg_next_m [CG_DEPTH];
  lcdid_op_t        op;
  logic [15:0]      word;
  logic             xfer_wr, accept, mapped, drop_clr;
  logic [CNT_W-1:0] exec_cyc;
  logic [5:0]       ac_stepped;
  // Counter step wraps inside the display RAM or the user/icon RAM span.
  function automatic logic [5:0] ac_step(input logic [5:0] ac, input logic cg, input logic up);
    logic [5:0] r;
    if (!cg)
      r = {2'b00, up ? ac[3:0] + 4'h1 : ac[3:0] - 4'h1};
    else if (up)
      r = (ac >= CG_LAST) ? 6'h00 : ac + 6'h01;
    else
      r = (ac == 6'h00) ? CG_LAST : ac - 6'h01;
    return r;
  endfunction
  // The transfer register is the host link; select bits pick the class.
  // A status read clears the drop flag, but a new drop in that cycle wins.
  assign word     = pwdata[15:0];
  assign xfer_wr  = psel && penable && pwrite && (paddr == OFF_XFER);
  assign drop_clr = psel && penable && !pwrite && (paddr == OFF_STATUS);
  // Classify the posted transfer.
  always_comb
  begin
    op = OP_NONE;
    case ({pwdata[XFER_TS_BIT], pwdata[XFER_RW_BIT], pwdata[XFER_RS_BIT]})
      3'b000:
        casez (word[7:0])
          8'b00000000: op = OP_TEST;
          8'b00000001: op = OP_CLEAR;
          8'b0000001?: op = OP_HOME;
          8'b000001??: op = OP_ENTRY;
          8'b00001???: op = OP_DISP;
          8'b0001????: op = OP_SHIFT;
          8'b01??????: op = OP_RATE;
          8'b10??????: op = OP_SETDD;
          8'b11??????: op = OP_SETCG;
          default:     op = OP_NONE;
        endcase
      3'b001:  op = word[9] ? OP_WRPORT : OP_WRRAM;
      3'b010:  op = OP_RDIN;
      3'b011:  op = OP_RDKEY;
      3'b110:  op = OP_RDBUSY;
      3'b111:  op = OP_RDRAM;
      default: op = OP_NONE;
    endcase
  end
  // Execution time per class; zero-time reads never raise busy.
  always_comb
  begin
    case (op)
      OP_CLEAR:          exec_cyc = CNT_W'(CLEAR_CYC);
      OP_SHIFT, OP_RDRAM: exec_cyc = CNT_W'(SHIFT_CYC);
      OP_RDIN, OP_RDKEY, OP_RDBUSY, OP_WRPORT, OP_NONE: exec_cyc = '0;
      default:           exec_cyc = CNT_W'(STD_CYC);
    endcase
  end
  // Zero-time transfers pass while busy; the rest are dropped to guard state.
  assign accept = xfer_wr && ((state_reg == ST_IDLE) || (exec_cyc == '0));
  assign ac_stepped = ac_step(ac_reg, cg_reg, inc_reg);
  // Instruction execution: every change of display state stems from here.
  always_comb
  begin
    state_next = state_reg;
    count_next = count_reg;
    instr_next = instr_reg;
    data_next  = data_reg;
    rdata_next = rdata_reg;
    ac_next    = ac_reg;
    cg_next    = cg_reg;
    inc_next   = inc_reg;
    shift_next = shift_reg;
    ofs_next   = ofs_reg;
    disp_next  = disp_reg;
    rate_next  = rate_reg;
    port_next  = port_reg;
    pat_next   = pat_reg;
    test_next  = test_reg;
    drop_next  = drop_reg && !drop_clr;
    dd_next    = dd_mem;
    cg_next_m  = cg_mem;
    if (state_reg == ST_EXEC)
    begin
      if (count_reg <= CNT_W'(1))
        state_next = ST_IDLE;
      count_next = count_reg - CNT_W'(1);
    end
    if (xfer_wr && !accept)
      drop_next = 1'b1;
    if (accept)
    begin
      if (exec_cyc != '0)
      begin
        state_next = ST_EXEC;
        count_next = exec_cyc;
      end
      if (!pwdata[XFER_RS_BIT] && !pwdata[XFER_RW_BIT])
        instr_next = word;
      else if (!pwdata[XFER_RW_BIT])
        data_next = word;
      case (op)
        OP_TEST: test_next = 1'b1;
        OP_CLEAR:
        begin
          for (int i = 0; i < DD_DEPTH; i++)
            dd_next[i] = SPACE_CODE;
          ac_next  = 6'h00;
          cg_next  = 1'b0;
          inc_next = 1'b1;
          ofs_next = 4'h0;
        end
        OP_HOME:
        begin
          ac_next  = 6'h00;
          cg_next  = 1'b0;
          ofs_next = 4'h0;
        end
        OP_ENTRY:
        begin
          inc_next   = word[1];
          shift_next = word[0];
        end
        OP_DISP:   disp_next = word[2:0];
        OP_SHIFT:
        begin
          if (word[3])
            ofs_next = word[2] ? ofs_reg - 4'h1 : ofs_reg + 4'h1;
          else
            ac_next = ac_step(ac_reg, cg_reg, word[2]);
        end
        OP_RATE:   rate_next = word[5:2];
        OP_SETDD:
        begin
          ac_next = {2'b00, word[3:0]};
          cg_next = 1'b0;
        end
        OP_SETCG:
        begin
          ac_next = (word[5:0] > CG_LAST) ? CG_LAST : word[5:0];
          cg_next = 1'b1;
        end
        OP_WRRAM:
        begin
          if (cg_reg)
            cg_next_m[ac_reg] = word[4:0];
          else
          begin
            dd_next[ac_reg[3:0]] = word[7:0];
            if (shift_reg)
              ofs_next = inc_reg ? ofs_reg + 4'h1 : ofs_reg - 4'h1;
          end
          ac_next = ac_stepped;
        end
        OP_WRPORT:
        begin
          port_next = word[5:0];
          pat_next  = word[8:7];
        end
        OP_RDIN:   rdata_next = {8'h00, input_port_pins};
        OP_RDKEY:  rdata_next = {4'h0, key_data};
        OP_RDBUSY: rdata_next = {9'h000, state_reg == ST_EXEC, ac_reg};
        OP_RDRAM:
        begin
          rdata_next = cg_reg ? {11'h000, cg_mem[ac_reg]}
                              : {8'h00, dd_mem[ac_reg[3:0]]};
          ac_next    = ac_stepped;
        end
        default: ;
      endcase
    end
  end
  // APB read data is captured in the setup cycle, so pready can stay high.
  always_comb
  begin
    mapped      = 1'b1;
    prdata_next = prdata_reg;
    if (paddr == OFF_XFER)
      prdata_next = {16'h0000, instr_reg};
    else if (paddr == OFF_STATUS)
    begin
      prdata_next = 32'h0000_0000;
      prdata_next[ST_BUSY_BIT]  = state_reg == ST_EXEC;
      prdata_next[ST_INC_BIT]   = inc_reg;
      prdata_next[ST_SHIFT_BIT] = shift_reg;
      prdata_next[ST_TEST_BIT]  = test_reg;
      prdata_next[ST_DROP_BIT]  = drop_reg;
      prdata_next[ST_CG_BIT]    = cg_reg;
      prdata_next[ST_AC_LSB +: 6]   = ac_reg;
      prdata_next[ST_OFS_LSB +: 4]  = ofs_reg;
      prdata_next[ST_DISP_LSB +: 3] = disp_reg;
    end
    else if (paddr == OFF_RDATA)
      prdata_next = {16'h0000, rdata_reg};
    else if (paddr == OFF_HOLD)
      prdata_next = {16'h0000, data_reg};
    else
    begin
      mapped      = 1'b0;
      prdata_next = 32'h0000_0000;
    end
    if (!(psel && !penable && !pwrite))
      prdata_next = prdata_reg;
  end
  // State registers.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state_reg  <= ST_IDLE;
      count_reg  <= '0;
      instr_reg  <= 16'h0000;
      data_reg   <= 16'h0000;
      rdata_reg  <= 16'h0000;
      prdata_reg <= 32'h0000_0000;
      ac_reg     <= 6'h00;
      cg_reg     <= 1'b0;
      inc_reg    <= 1'b1;
      shift_reg  <= 1'b0;
      ofs_reg    <= 4'h0;
      disp_reg   <= DISP_RST;
      rate_reg   <= RATE_RST;
      port_reg   <= 6'h00;
      pat_reg    <= 2'b00;
      test_reg   <= 1'b0;
      drop_reg   <= 1'b0;
      dd_mem     <= '{default: SPACE_CODE};
      cg_mem     <= '{default: 5'h00};
    end
    else
    begin
      state_reg  <= state_next;
      count_reg  <= count_next;
      instr_reg  <= instr_next;
      data_reg   <= data_next;
      rdata_reg  <= rdata_next;
      prdata_reg <= prdata_next;
      ac_reg     <= ac_next;
      cg_reg     <= cg_next;
      inc_reg    <= inc_next;
      shift_reg  <= shift_next;
      ofs_reg    <= ofs_next;
      disp_reg   <= disp_next;
      rate_reg   <= rate_next;
      port_reg   <= port_next;
      pat_reg    <= pat_next;
      test_reg   <= test_next;
      drop_reg   <= drop_next;
      dd_mem     <= dd_next;
      cg_mem     <= cg_next_m;
    end
  end
  // Outputs.
  assign prdata          = prdata_reg;
  assign pready          = 1'b1;
  assign pslverr         = psel && penable && !mapped;
  assign busy_flag       = state_reg == ST_EXEC;
  assign address_counter = ac_reg;
  assign display_shift   = ofs_reg;
  assign display_ctrl    = disp_reg;
  assign sample_rate     = rate_reg;
  assign port_out        = port_reg;
  assign port_pattern    = pat_reg;
  assign test_mode       = test_reg;

endmodule
`default_nettype wire

// ---- lcdid_pkg.sv ----
/*
  Shared constants for the character LCD instruction decoder: register
  offsets, field positions, reset values, opcodes and execution times.
  Assumes a 250 MHz system clock and a nominal 69 kHz display oscillator.
*/
package lcdid_pkg;
  // Clock and execution times (ns at the nominal oscillator rate).
  localparam int CLK_MHZ       = 250;
  localparam int EXEC_STD_NS   = 217000;
  localparam int EXEC_SHIFT_NS = 290000;
  localparam int EXEC_CLEAR_NS = 1380000;
  localparam int EXEC_STD_CYC   = (EXEC_STD_NS * CLK_MHZ + 999) / 1000;
  localparam int EXEC_SHIFT_CYC = (EXEC_SHIFT_NS * CLK_MHZ + 999) / 1000;
  localparam int EXEC_CLEAR_CYC = (EXEC_CLEAR_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W          = 20;

  // APB register byte offsets.
  localparam logic [11:0] OFF_XFER   = 12'h000;
  localparam logic [11:0] OFF_STATUS = 12'h004;
  localparam logic [11:0] OFF_RDATA  = 12'h008;
  localparam logic [11:0] OFF_HOLD   = 12'h00c;

  // Transfer register fields.
  localparam int XFER_RS_BIT = 16;
  localparam int XFER_RW_BIT = 17;
  localparam int XFER_TS_BIT = 18;

  // Status register fields.
  localparam int ST_BUSY_BIT  = 0;
  localparam int ST_INC_BIT   = 1;
  localparam int ST_SHIFT_BIT = 2;
  localparam int ST_TEST_BIT  = 3;
  localparam int ST_DROP_BIT  = 4;
  localparam int ST_CG_BIT    = 5;
  localparam int ST_AC_LSB    = 8;
  localparam int ST_OFS_LSB   = 16;
  localparam int ST_DISP_LSB  = 20;

  // Memory layout and reset values.
  localparam int          DD_DEPTH   = 16;
  localparam int          CG_DEPTH   = 48;
  localparam logic [5:0]  CG_LAST    = 6'h2f;
  localparam logic [7:0]  SPACE_CODE = 8'h20;
  localparam logic [2:0]  DISP_RST   = 3'h0;
  localparam logic [3:0]  RATE_RST   = 4'h0;

  // Decoded transfer classes.
  typedef enum logic [3:0] {
    OP_NONE = 4'b0000, OP_TEST = 4'b0001, OP_CLEAR = 4'b0010,
    OP_HOME = 4'b0011, OP_ENTRY = 4'b0100, OP_DISP = 4'b0101,
    OP_SHIFT = 4'b0110, OP_RATE = 4'b0111, OP_SETDD = 4'b1000,
    OP_SETCG = 4'b1001, OP_WRRAM = 4'b1010, OP_WRPORT = 4'b1011,
    OP_RDIN = 4'b1100, OP_RDKEY = 4'b1101, OP_RDBUSY = 4'b1110,
    OP_RDRAM = 4'b1111
  } lcdid_op_t;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_EXEC = 1'b1
  } lcdid_state_t;
endpackage

// ---- lcdid_decoder_checker.sv ----
/*
  Port checker for the LCD instruction decoder.
  Assumes a transfer is posted by an APB write to the transfer register
  and that its effects and busy appear one edge after that write.
*/
`timescale 1ns/1ps
`default_nettype none
module lcdid_decoder_checker
  import lcdid_pkg::*;
#(
  parameter int STD_CYC   = 5,
  parameter int SHIFT_CYC = 7,
  parameter int CLEAR_CYC = 20
)(
  // Clock and reset.
  input wire logic        clock,
  input wire logic        rst,
  // APB.
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Sensed inputs.
  input wire logic [7:0]  input_port_pins,
  input wire logic [11:0] key_data,
  // Display state.
  input wire logic        busy_flag,
  input wire logic [5:0]  address_counter,
  input wire logic [3:0]  display_shift,
  input wire logic [2:0]  display_ctrl,
  input wire logic [3:0]  sample_rate,
  input wire logic [5:0]  port_out,
  input wire logic [1:0]  port_pattern,
  input wire logic        test_mode
);
  logic wr_x;
  logic acc;
  logic ins;
  int   run_reg;
  int   run_next;
  int   exp_reg;
  int   exp_next;

  // A write refused while busy must not count as an accepted transfer.
  assign wr_x = psel && penable && pwrite && paddr == OFF_XFER;
  assign acc  = wr_x && !busy_flag;
  assign ins  = acc && pwdata[18:16] == 3'b000;

  // Expected busy length is latched from the accepted word; run counts busy cycles.
  always_comb
  begin
    exp_next = exp_reg;
    if (ins && pwdata[7:0] == 8'h01)
      exp_next = CLEAR_CYC;
    else if ((ins && pwdata[7:4] == 4'h1) || (acc && pwdata[18:16] == 3'b111))
      exp_next = SHIFT_CYC;
    else if (acc)
      exp_next = STD_CYC;
    run_next = busy_flag ? run_reg + 1 : 0;
  end

  // Helper registers.
  always_ff @(posedge clock)
  begin
    exp_reg <= rst ? 0 : exp_next;
    run_reg <= rst ? 0 : run_next;
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  a_clear_state: assert property (ins && pwdata[7:0] == 8'h01 |=> address_counter == 6'h00)
    else $error("clear left the address counter nonzero");
  a_clear_cursor: assert property (ins && pwdata[7:0] == 8'h01 |=> display_shift == 4'h0 ##1 busy_flag)
    else $error("clear left the cursor offset");
  a_home_addr: assert property (ins && pwdata[7:1] == 7'h01 |=> address_counter == 6'h00)
    else $error("home left the address counter nonzero");
  a_home_shift: assert property (ins && pwdata[7:1] == 7'h01 |=> display_shift == 4'h0)
    else $error("home kept a display shift");
  a_test_entry: assert property (ins && pwdata[7:0] == 8'h00 |=> test_mode && busy_flag)
    else $error("test word did not enter test mode");
  a_zero_time: assert property (acc && pwdata[18:17] == 2'b01 |=> !busy_flag)
    else $error("zero time read raised busy");
  a_busy_rise: assert property (acc && pwdata[18:16] == 3'b111 |=> busy_flag [*2])
    else $error("RAM read did not hold busy");
  a_busy_len: assert property ($fell(busy_flag) |-> run_reg == exp_reg)
    else $error("busy length differs from execution time");
  a_ac_quiet: assert property (!wr_x |=> $stable(address_counter))
    else $error("address counter moved without a transfer");
endmodule

bind lcdid_decoder lcdid_decoder_checker #(.STD_CYC(STD_CYC), .SHIFT_CYC(SHIFT_CYC),
  .CLEAR_CYC(CLEAR_CYC)) u_chk (.clock(clock), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .input_port_pins(input_port_pins),
  .key_data(key_data), .busy_flag(busy_flag), .address_counter(address_counter),
  .display_shift(display_shift), .display_ctrl(display_ctrl), .sample_rate(sample_rate),
  .port_out(port_out), .port_pattern(port_pattern), .test_mode(test_mode));
`default_nettype wire

// ---- lcdid_host.sv ----
/*
  Host model: posts transfers to the decoder over APB.
  Assumes the transfer register layout of the decoder package.
*/
`timescale 1ns/1ps
`default_nettype none
module lcdid_host
  import lcdid_pkg::*;
(
  // Clock.
  input  wire logic        clock,
  // APB master.
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  // Device status.
  input  wire logic        busy_flag
);
  // Idle bus at time zero.
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'hfff;
    pwdata = 32'h0;
  end

  // One APB transfer; the released bus shows inverted values so stale data never matches.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do
      @(posedge clock);
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask

  // Waits for idle, then posts select bits and word.
  task automatic send(input logic [2:0] s, input logic [15:0] w);
    logic [31:0] q;
    logic        e;
    @(negedge clock);
    while (busy_flag !== 1'b0)
      @(negedge clock);
    xfer(1'b1, OFF_XFER, {13'h0, s, w}, q, e);
  endtask
endmodule
`default_nettype wire

// ---- tb.sv ----
/*
  Self-checking bench for the LCD instruction decoder.
  Assumes the host model drives APB and short execution counts.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) \
  begin \
    comparisons++; \
    if ((a) !== (b)) \
    begin \
      err_total++; \
      $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); \
    end \
  end
module tb
  import lcdid_pkg::*;
;
  localparam int STD = 5;
  localparam int SHF = 7;
  localparam int CLR = 20;
  logic        clock;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  pins;
  logic [11:0] keys;
  logic        busy_flag;
  logic [5:0]  address_counter;
  logic [3:0]  display_shift;
  logic [2:0]  display_ctrl;
  logic [3:0]  sample_rate;
  logic [5:0]  port_out;
  logic [1:0]  port_pattern;
  logic        test_mode;
  logic [31:0] q;
  logic        e;
  int          err_total;
  int          comparisons;
  int          cyc = 0;

  lcdid_decoder #(.STD_CYC(STD), .SHIFT_CYC(SHF), .CLEAR_CYC(CLR)) u_lcdid_decoder (
    .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .input_port_pins(pins), .key_data(keys), .busy_flag(busy_flag),
    .address_counter(address_counter), .display_shift(display_shift),
    .display_ctrl(display_ctrl), .sample_rate(sample_rate), .port_out(port_out),
    .port_pattern(port_pattern), .test_mode(test_mode));

  lcdid_host u_host (.clock(clock), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .busy_flag(busy_flag));

  // Clock at 250 MHz.
  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // Prints counts and the verdict, then stops.
  task automatic end_sim();
    $display("counts: %0d compared, %0d mismatched", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Cuts a hang short; the whole run needs well under a thousand cycles.
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      err_total++;
      end_sim();
    end
  end

  task automatic rd(input logic [11:0] a);
    u_host.xfer(1'b0, a, 32'h0, q, e);
  endtask

  // Posts a transfer and counts its busy cycles.
  task automatic run(input logic [2:0] s, input logic [15:0] w, input int n);
    int c;
    u_host.send(s, w);
    c = 0;
    @(negedge clock);
    while (busy_flag === 1'b1 && c < 400)
    begin
      c++;
      @(negedge clock);
    end
    `CHK(c, n)
  endtask

  task automatic t_reset();
    rd(OFF_STATUS);
    `CHK(q, 32'h0000_0002)
    u_host.xfer(1'b0, 12'h010, 32'h0, q, e);
    `CHK({e, q}, {1'b1, 32'h0})
    $display("reset test done");
  endtask

  task automatic t_step();
    run(3'b000, 16'h0085, STD);
    run(3'b001, 16'h0041, STD);
    `CHK(address_counter, 6'h06)
    rd(OFF_HOLD);
    `CHK(q[15:0], 16'h0041)
    rd(OFF_XFER);
    `CHK(q[15:0], 16'h0085)
    run(3'b000, 16'h0004, STD);
    run(3'b001, 16'h0042, STD);
    `CHK(address_counter, 6'h05)
    run(3'b000, 16'h000e, STD);
    run(3'b000, 16'h0074, STD);
    `CHK({display_ctrl, sample_rate}, {3'h6, 4'hd})
    $display("entry step test done");
  endtask

  task automatic t_clear();
    run(3'b000, 16'h0005, STD);
    run(3'b000, 16'h00c4, STD);
    run(3'b001, 16'h0013, STD);
    run(3'b000, 16'h001c, SHF);
    `CHK(display_shift, 4'hf)
    run(3'b000, 16'h0083, STD);
    run(3'b000, 16'hff01, CLR);
    `CHK(address_counter, 6'h00)
    `CHK(display_shift, 4'h0)
    `CHK(display_ctrl, 3'h6)
    rd(OFF_STATUS);
    `CHK(q[2:1], 2'b11)
    run(3'b000, 16'h00c4, STD);
    run(3'b111, 16'h0000, SHF);
    rd(OFF_RDATA);
    `CHK(q[4:0], 5'h13)
    run(3'b000, 16'h0085, STD);
    run(3'b111, 16'h0000, SHF);
    rd(OFF_RDATA);
    `CHK(q[7:0], SPACE_CODE)
    `CHK(address_counter, 6'h06)
    $display("clear test done");
  endtask

  task automatic t_home();
    run(3'b000, 16'h0082, STD);
    run(3'b001, 16'h0055, STD);
    run(3'b000, 16'h0018, SHF);
    `CHK(display_shift, 4'h2)
    run(3'b000, 16'hab03, STD);
    `CHK({address_counter, display_shift}, {6'h00, 4'h0})
    run(3'b000, 16'h0082, STD);
    run(3'b111, 16'h0000, SHF);
    rd(OFF_RDATA);
    `CHK(q[7:0], 8'h55)
    $display("home test done");
  endtask

  task automatic t_zero();
    pins <= 8'h5a;
    keys <= 12'ha5c;
    run(3'b010, 16'h0000, 0);
    rd(OFF_RDATA);
    `CHK(q[7:0], 8'h5a)
    run(3'b011, 16'h0000, 0);
    rd(OFF_RDATA);
    `CHK(q[11:0], 12'ha5c)
    run(3'b110, 16'h0000, 0);
    rd(OFF_RDATA);
    `CHK(q[6:0], 7'h03)
    run(3'b001, 16'h03bf, 0);
    `CHK({port_pattern, port_out}, {2'b11, 6'h3f})
    run(3'b100, 16'h0001, 0);
    `CHK(address_counter, 6'h03)
    $display("zero time test done");
  endtask

  // A word posted while busy is dropped and flagged.
  task automatic t_test();
    u_host.send(3'b000, 16'h0083);
    u_host.xfer(1'b1, OFF_XFER, 32'h0000_0081, q, e);
    run(3'b000, 16'h5500, STD);
    `CHK({test_mode, address_counter}, {1'b1, 6'h03})
    rd(OFF_STATUS);
    `CHK(q[4:3], 2'b11)
    rd(OFF_STATUS);
    `CHK(q[4:3], 2'b01)
    $display("test mode test done");
  endtask

  // Main sequence.
  initial
  begin
    err_total = 0;
    comparisons = 0;
    rst = 1'b1;
    pins = 8'h00;
    keys = 12'h000;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    t_reset();
    t_step();
    t_clear();
    t_home();
    t_zero();
    t_test();
    end_sim();
  end
endmodule
`default_nettype wire
